// file: logic/idc_pkg.sv
// Purpose: constants and carriers for the identify command decoder and the
//          controller information assembler
// Assumes: 32-bit register port, byte-wide response path
// Notes:   Functional notes follow
// Functional notes
// - Take target_controller_id from command dword ten bits 31:16.
// - With namespace management present, target_controller_id is honoured, not dropped.
// - Dword ten bits 7:0 are structure_select_code; bits 15:8 reserved.
// - Bytes 1:0 carry vendor_identifier from the configuration identification register.
// - Bytes 3:2 carry subsystem_vendor_identifier from the configuration subsystem register.
// - Bytes 23:4 carry serial_string as ASCII.
// - Bytes 63:24 carry model_string as ASCII.
// - Bytes 71:64 carry active firmware_revision_string, same as the firmware log.
// - Byte 72 carries arbitration_burst_hint.
// - Bytes 75:73 carry the vendor organization unique identifier.
// - multipath_sharing_caps bit 2 set for virtual function, clear for physical.
// - multipath_sharing_caps bit 1 set when two or more controllers may exist.
// - multipath_sharing_caps bit 0 set for two or more ports; bits 7:3 reserved.
// - Code 01h returns the controller information structure for this controller.

package idc_pkg;

    localparam logic [7:0] IDC_SEL_CTRL_INFO = 8'h01;
    localparam logic [6:0] IDC_STRUCT_BYTES = 7'h4D;
    localparam logic [6:0] IDC_LAST_INDEX = 7'h4C;

    // structure byte positions
    localparam logic [6:0] IDC_B_SUBSYS = 7'h02;
    localparam logic [6:0] IDC_B_STR = 7'h04;
    localparam logic [6:0] IDC_B_BURST = 7'h48;
    localparam logic [6:0] IDC_B_OUI = 7'h49;
    localparam logic [6:0] IDC_B_CAPS = 7'h4C;
    localparam int IDC_STR_BYTES = 68;
    localparam int IDC_STR_WORDS = 17;
    localparam logic [7:0] IDC_STR_RST = 8'h20;

    // register offsets (byte addresses)
    localparam logic [7:0] IDC_CTRL_OFS = 8'h00;
    localparam logic [7:0] IDC_OUI_OFS = 8'h04;
    localparam logic [7:0] IDC_STAT_OFS = 8'h08;
    localparam logic [7:0] IDC_LAST_OFS = 8'h0C;
    localparam logic [7:0] IDC_STR_OFS = 8'h40;
    localparam logic [7:0] IDC_STR_END = 8'h84;

    // control register fields
    localparam int IDC_CTRL_BURST_LSB = 0;
    localparam int IDC_CTRL_MP_BIT = 8;
    localparam int IDC_CTRL_MC_BIT = 9;
    localparam int IDC_CTRL_VF_BIT = 10;
    localparam logic [7:0] IDC_BURST_RST = 8'h00;
    localparam logic [23:0] IDC_OUI_RST = 24'h000000;

    typedef struct packed {
        logic [15:0] target_id;
        logic [7:0] rsvd;
        logic [7:0] sel;
    } idc_dw10_type;

    typedef struct packed {
        logic last;
        logic [6:0] index;
        logic [7:0] data;
    } idc_beat_type;

endpackage : idc_pkg

// file: logic/idc_identify_ctrl_info.sv
// Purpose: decode identify dword ten and stream the first 77 bytes of the
//          controller information structure
// Assumes: response buffer accepts bytes with valid/ready; second_data_pointer
//          handled by the data mover upstream
// Notes:   strings default to ASCII spaces; software loads them before use
`timescale 1ns/100ps
`default_nettype none

module idc_identify_ctrl_info
    import idc_pkg::*;
#(
    parameter int NS_MGMT = 1
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic cmd_valid,
    input wire idc_dw10_type cmd_dw10,
    output logic cmd_ready,
    input wire logic [15:0] cfg_vendor_id,
    input wire logic [15:0] cfg_subsys_vendor_id,
    output logic sel_strobe,
    output logic [7:0] structure_select_code,
    output logic [15:0] target_controller_id,
    output logic sel_other,
    output logic beat_valid,
    output idc_beat_type beat,
    input wire logic beat_ready,
    output logic busy
);

    generate
        if (NS_MGMT != 0 && NS_MGMT != 1) begin : g_bad_param
            $error("NS_MGMT must be 0 or 1");
        end
    endgenerate

    typedef enum logic {
        IDC_IDLE = 1'b0,
        IDC_SEND = 1'b1
    } idc_state_type;

    idc_state_type state_reg;
    idc_state_type state_next;

    logic [7:0] str_reg [0:IDC_STR_BYTES-1];
    logic [7:0] burst_reg;
    logic mp_reg;
    logic mc_reg;
    logic vf_reg;
    logic [23:0] oui_reg;
    logic [15:0] done_cnt_reg;
    logic [31:0] rdata_reg;
    idc_beat_type beat_reg;
    logic sel_strobe_reg;
    logic sel_other_reg;
    logic [7:0] sel_code_reg;
    logic [15:0] target_id_reg;

    // address decode shared by read and write paths
    function automatic logic is_str(input logic [7:0] a);
        is_str = (a >= IDC_STR_OFS) && (a < IDC_STR_END) && (a[1:0] == 2'h0);
    endfunction : is_str

    function automatic logic [4:0] str_word(input logic [7:0] a);
        logic [7:0] d;
        d = a - IDC_STR_OFS;
        str_word = d[6:2];
    endfunction : str_word

    wire logic hit_ctrl = reg_addr == IDC_CTRL_OFS;
    wire logic hit_oui = reg_addr == IDC_OUI_OFS;
    wire logic hit_stat = reg_addr == IDC_STAT_OFS;
    wire logic hit_last = reg_addr == IDC_LAST_OFS;
    wire logic hit_str = is_str(reg_addr);
    wire logic [4:0] wr_word = str_word(reg_addr);

    wire logic cmd_take = cmd_valid && (state_reg == IDC_IDLE);
    // reserved bits 15:8 are never looked at
    wire logic [7:0] cmd_sel = cmd_dw10.sel;
    wire logic take_info = cmd_take && (cmd_sel == IDC_SEL_CTRL_INFO);
    wire logic beat_fire = (state_reg == IDC_SEND) && beat_ready;
    wire logic send_end = beat_fire && beat_reg.last;

    // without namespace management no selection uses the identifier
    wire logic [15:0] cmd_target_id = (NS_MGMT == 1) ? cmd_dw10.target_id
                                                     : 16'h0000;

    wire logic [7:0] caps_byte = {5'h00, vf_reg, mc_reg, mp_reg};

    // byte at one position of the structure; numeric fields low byte first
    function automatic logic [7:0] struct_byte(input logic [6:0] idx);
        logic [6:0] s;
        s = idx - IDC_B_STR;
        if (idx < IDC_B_SUBSYS) begin
            struct_byte = idx[0] ? cfg_vendor_id[15:8] : cfg_vendor_id[7:0];
        end else if (idx < IDC_B_STR) begin
            struct_byte = idx[0] ? cfg_subsys_vendor_id[15:8]
                                 : cfg_subsys_vendor_id[7:0];
        end else if (idx < IDC_B_BURST) begin
            // serial, model and firmware strings share one byte array
            struct_byte = str_reg[s];
        end else if (idx == IDC_B_BURST) begin
            struct_byte = burst_reg;
        end else if (idx < IDC_B_CAPS) begin
            struct_byte = oui_reg[8*(idx-IDC_B_OUI) +: 8];
        end else begin
            struct_byte = caps_byte;
        end
    endfunction : struct_byte

    wire logic [6:0] next_index = (state_reg == IDC_IDLE) ? 7'h00
                                                          : 7'(beat_reg.index + 7'h01);
    wire logic [7:0] next_data = struct_byte(next_index);
    wire logic load_beat = take_info || (beat_fire && !beat_reg.last);

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            IDC_IDLE: begin
                if (take_info) begin
                    state_next = IDC_SEND;
                end
            end
            IDC_SEND: begin
                if (send_end) begin
                    state_next = IDC_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_reg <= IDC_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // bytes are latched one beat ahead; a software write during a send only
    // affects bytes not yet latched
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            beat_reg <= '0;
        end else if (load_beat) begin
            beat_reg.index <= next_index;
            beat_reg.data <= next_data;
            beat_reg.last <= next_index == IDC_LAST_INDEX;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sel_strobe_reg <= 1'b0;
            sel_other_reg <= 1'b0;
            sel_code_reg <= 8'h00;
            target_id_reg <= 16'h0000;
        end else begin
            sel_strobe_reg <= cmd_take;
            sel_other_reg <= cmd_take && !take_info;
            if (cmd_take) begin
                sel_code_reg <= cmd_sel;
                target_id_reg <= cmd_target_id;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            done_cnt_reg <= 16'h0000;
        end else if (send_end) begin
            done_cnt_reg <= 16'(done_cnt_reg + 16'h0001);
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            burst_reg <= IDC_BURST_RST;
            mp_reg <= 1'b0;
            mc_reg <= 1'b0;
            vf_reg <= 1'b0;
        end else if (reg_wr && hit_ctrl) begin
            burst_reg <= reg_wdata[IDC_CTRL_BURST_LSB +: 8];
            mp_reg <= reg_wdata[IDC_CTRL_MP_BIT];
            mc_reg <= reg_wdata[IDC_CTRL_MC_BIT];
            vf_reg <= reg_wdata[IDC_CTRL_VF_BIT];
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            oui_reg <= IDC_OUI_RST;
        end else if (reg_wr && hit_oui) begin
            oui_reg <= reg_wdata[23:0];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < IDC_STR_BYTES; gi++) begin : g_str
            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    str_reg[gi] <= IDC_STR_RST;
                end else if (reg_wr && hit_str && (wr_word == 5'(gi / 4))) begin
                    str_reg[gi] <= reg_wdata[8*(gi%4) +: 8];
                end
            end
        end
    endgenerate

    wire logic [4:0] rd_word = str_word(reg_addr);
    wire logic [31:0] rd_str = {str_reg[{rd_word, 2'h3}], str_reg[{rd_word, 2'h2}],
                                str_reg[{rd_word, 2'h1}], str_reg[{rd_word, 2'h0}]};
    wire logic [31:0] rd_ctrl = {21'h000000, vf_reg, mc_reg, mp_reg, burst_reg};
    wire logic [31:0] rd_stat = {done_cnt_reg, 1'b0, beat_reg.index, 7'h00, busy};
    wire logic [31:0] rd_last = {target_id_reg, 8'h00, sel_code_reg};
    wire logic [31:0] rd_mux = hit_ctrl ? rd_ctrl
                             : hit_oui ? {8'h00, oui_reg}
                             : hit_stat ? rd_stat
                             : hit_last ? rd_last
                             : hit_str ? rd_str
                             : 32'h00000000;

    // read data stand for exactly the cycle after the strobe
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdata_reg <= 32'h00000000;
        end else if (reg_rd) begin
            rdata_reg <= rd_mux;
        end else begin
            rdata_reg <= 32'h00000000;
        end
    end

    assign reg_rdata = rdata_reg;
    assign cmd_ready = state_reg == IDC_IDLE;
    assign busy = state_reg == IDC_SEND;
    assign beat_valid = state_reg == IDC_SEND;
    assign beat = beat_reg;
    assign sel_strobe = sel_strobe_reg;
    assign sel_other = sel_other_reg;
    assign structure_select_code = sel_code_reg;
    assign target_controller_id = target_id_reg;

endmodule : idc_identify_ctrl_info

`default_nettype wire

// file: bench/idc_checker_assertions.sv
// Purpose: protocol checker for the identify decoder ports
// Assumes: NS_MGMT left at 1, so target ids are kept
// Notes: beat data is held against the live config inputs
`timescale 1ns/100ps
`default_nettype none
module idc_checker
    import idc_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic cmd_valid,
    input wire idc_dw10_type cmd_dw10,
    input wire logic cmd_ready,
    input wire logic [15:0] cfg_vendor_id,
    input wire logic [15:0] cfg_subsys_vendor_id,
    input wire logic sel_strobe,
    input wire logic [7:0] structure_select_code,
    input wire logic [15:0] target_controller_id,
    input wire logic sel_other,
    input wire logic beat_valid,
    input wire idc_beat_type beat,
    input wire logic beat_ready
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    wire logic take = cmd_valid && cmd_ready;
    wire logic is_info = cmd_dw10.sel == IDC_SEL_CTRL_INFO;

    a_code_capture: assert property (
        take |=> sel_strobe && structure_select_code == $past(cmd_dw10.sel))
        else $error("select code not captured");
    a_target_capture: assert property (
        take |=> target_controller_id == $past(cmd_dw10.target_id))
        else $error("target id not captured");
    a_info_start: assert property (
        take && is_info |=> beat_valid && beat.index == 7'h00)
        else $error("information stream did not start");
    a_other_quiet: assert property (
        take && !is_info |=> sel_other && !beat_valid)
        else $error("other code started a stream");
    a_vendor_high: assert property (
        beat_valid && beat.index == 7'h01 |-> beat.data == cfg_vendor_id[15:8])
        else $error("vendor byte wrong");
    a_subsys_low: assert property (
        beat_valid && beat.index == IDC_B_SUBSYS |-> beat.data == cfg_subsys_vendor_id[7:0])
        else $error("subsystem vendor byte wrong");
    a_caps_reserved: assert property (
        beat_valid && beat.index == IDC_B_CAPS |-> beat.last && beat.data[7:3] == 5'h00)
        else $error("capability byte wrong");
    a_beat_order: assert property (
        beat_valid && beat_ready && !beat.last |=>
        beat_valid && beat.index == $past(beat.index) + 7'h01)
        else $error("beat order broken");
    a_beat_hold: assert property (
        beat_valid && !beat_ready |=> beat_valid && $stable(beat))
        else $error("beat changed while stalled");
    a_last_frees: assert property (
        beat_valid && beat_ready && beat.last |=>
        !beat_valid && cmd_ready)
        else $error("stream did not end");
endmodule : idc_checker

bind idc_identify_ctrl_info idc_checker idc_checker_i (.mclk(mclk), .sys_rst(sys_rst),
    .cmd_valid(cmd_valid), .cmd_dw10(cmd_dw10), .cmd_ready(cmd_ready),
    .cfg_vendor_id(cfg_vendor_id), .cfg_subsys_vendor_id(cfg_subsys_vendor_id),
    .sel_strobe(sel_strobe), .structure_select_code(structure_select_code),
    .target_controller_id(target_controller_id), .sel_other(sel_other),
    .beat_valid(beat_valid), .beat(beat), .beat_ready(beat_ready));
`default_nettype wire

// file: bench/idc_sink_model.sv
// Purpose: host-side response buffer taking the structure bytes
// Assumes: one direct page holds all 77 bytes
// Notes: stall accepts only one beat in four
`timescale 1ns/100ps
`default_nettype none
module idc_sink_model
    import idc_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic stall,
    input wire logic beat_valid,
    input wire idc_beat_type beat,
    output logic beat_ready
);
    // a single page buffer, never a pointer list
    logic [7:0] mem [0:76];
    logic [1:0] phase_reg;
    initial beat_ready = 1'b0;
    always @(posedge mclk) begin
        phase_reg <= sys_rst ? 2'h0 : phase_reg + 2'h1;
        beat_ready <= !sys_rst && (!stall || phase_reg == 2'h3);
        if (beat_valid && beat_ready) begin
            mem[beat.index] <= beat.data;
        end
    end
endmodule : idc_sink_model
`default_nettype wire

// file: bench/testbench.sv
// Purpose: self-checking bench for the identify decoder
// Assumes: sink model stalls on request
// Notes: expected bytes come from row data and config values
`timescale 1ns/100ps
`default_nettype none
module testbench
    import idc_pkg::*;
;
    typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} idc_row_type;
    localparam idc_row_type ROWS [6] = '{'{8'h00, 32'h0000_0603, 32'h0000_0603},
        '{8'h04, 32'h00AC_DE48, 32'h00AC_DE48}, '{8'h40, 32'h3130_5341, 32'h3130_5341},
        '{8'h80, 32'h3332_2E31, 32'h3332_2E31}, '{8'h30, 32'hFFFF_FFFF, 32'h0},
        '{8'h42, 32'h5555_5555, 32'h0}};
    localparam logic [7:0] CODES [5] = '{8'h00, 8'h02, 8'h12, 8'h13, 8'hFF};
    localparam logic [31:0] CFG_IDS = 32'h3C4D_1A2B;
    logic mclk, sys_rst, reg_wr, reg_rd, cmd_valid, cmd_ready, sel_strobe, sel_other;
    logic beat_valid, beat_ready, busy, stall;
    logic [7:0] reg_addr, structure_select_code, exp_b [0:76];
    logic [31:0] reg_wdata, reg_rdata, v, tail;
    logic [15:0] target_controller_id, id;
    idc_dw10_type cmd_dw10;
    idc_beat_type beat;
    int mismatches, samples_checked;

    idc_identify_ctrl_info idc_identify_ctrl_info_i (.mclk(mclk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .cmd_valid(cmd_valid), .cmd_dw10(cmd_dw10),
        .cmd_ready(cmd_ready), .cfg_vendor_id(CFG_IDS[15:0]),
        .cfg_subsys_vendor_id(CFG_IDS[31:16]), .sel_strobe(sel_strobe),
        .structure_select_code(structure_select_code),
        .target_controller_id(target_controller_id), .sel_other(sel_other),
        .beat_valid(beat_valid), .beat(beat), .beat_ready(beat_ready), .busy(busy));
    idc_sink_model idc_sink_model_i (.mclk(mclk), .sys_rst(sys_rst), .stall(stall),
        .beat_valid(beat_valid), .beat(beat), .beat_ready(beat_ready));

    always #2 mclk = ~mclk;

    task automatic report_and_stop();
        $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        // data stand for this one cycle; take them mid-cycle, clear of the edges
        @(negedge mclk);
        d = reg_rdata;
        @(posedge mclk);
    endtask : rd

    // reserved dword bits are set to show they are ignored
    task automatic send_cmd(input logic [7:0] s, input logic [15:0] t);
        int n;
        n = 0;
        cmd_dw10 <= '{t, 8'hFF, s};
        cmd_valid <= 1'b1;
        // ready is looked at mid-cycle, so the taking edge is known beforehand
        do begin
            @(negedge mclk);
            n++;
        end while (cmd_ready !== 1'b1 && n < 200);
        @(posedge mclk);
        cmd_valid <= 1'b0;
        if (n >= 200) begin
            mismatches++;
            report_and_stop();
        end
    endtask : send_cmd

    initial begin
        mclk = 1'b0;
        sys_rst = 1'b1;
        {reg_addr, reg_wdata, reg_wr, reg_rd, cmd_valid, cmd_dw10, stall} = '0;
        mismatches = 0;
        samples_checked = 0;
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        foreach (ROWS[i]) begin
            wr(ROWS[i].a, ROWS[i].d);
            rd(ROWS[i].a, v);
            chk("register", ROWS[i].e, v);
        end
        tail = {ROWS[1].d[23:0], ROWS[0].d[7:0]};
        for (int i = 0; i < 77; i++) exp_b[i] = 8'h20;
        for (int i = 0; i < 4; i++) begin
            exp_b[i] = CFG_IDS[8*i+:8];
            exp_b[4+i] = ROWS[2].d[8*i+:8];
            exp_b[68+i] = ROWS[3].d[8*i+:8];
            exp_b[72+i] = tail[8*i+:8];
        end
        exp_b[76] = {5'h00, ROWS[0].d[10:8]};
        stall <= 1'b1;
        send_cmd(IDC_SEL_CTRL_INFO, 16'h0000);
        for (int n = 0; n < 1000; n++) begin
            @(posedge mclk);
            if (beat_valid === 1'b0) break;
            if (n == 999) begin
                mismatches++;
                report_and_stop();
            end
        end
        for (int i = 0; i < 77; i++) begin
            chk("byte", {24'h0, exp_b[i]}, {24'h0, idc_sink_model_i.mem[i]});
        end
        // one finished stream, beat index left on the last byte, idle
        rd(IDC_STAT_OFS, v);
        chk("status", {16'h0001, 1'b0, IDC_LAST_INDEX, 8'h00}, v);
        foreach (CODES[i]) begin
            id = CODES[i][4] ? 16'h0ABC : 16'h0000;
            @(posedge mclk);
            send_cmd(CODES[i], id);
            #1;
            chk("code", {24'h0, CODES[i]}, {24'h0, structure_select_code});
            chk("target id", {16'h0, id}, {16'h0, target_controller_id});
            chk("other", 32'h1, {31'h0, sel_other & !beat_valid});
            @(posedge mclk);
            rd(IDC_LAST_OFS, v);
            chk("last", {id, 8'h00, CODES[i]}, v);
        end
        // reset in mid-stream must drop the stream and restore defaults
        @(posedge mclk);
        send_cmd(IDC_SEL_CTRL_INFO, 16'h0000);
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b1;
        @(posedge mclk);
        sys_rst <= 1'b0;
        #1;
        chk("idle", 32'h1, {29'h0, busy, beat_valid, cmd_ready});
        @(posedge mclk);
        rd(IDC_CTRL_OFS, v);
        chk("ctrl reset", 32'h0, v);
        // this word was written earlier, so the spaces prove the reset
        rd(IDC_STR_OFS, v);
        chk("string reset", 32'h2020_2020, v);
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
